/* hdl/fault_status_defines.svh */
/*
  Constants for the half-bridge fault status bank: address byte layout,
  register select codes and reset value.
  Assumes a plain include by bare name; no other dependency.
*/
`ifndef FAULT_STATUS_DEFINES_SVH
`define FAULT_STATUS_DEFINES_SVH

// ****************************************************************
// Address byte layout
// ****************************************************************
`define ADDR_OP_BIT 7
`define ADDR_SEL_HI 6
`define ADDR_SEL_LO 2
`define ADDR_ACCESS_TYPE_BIT 1
`define ADDR_FIXED_BIT 0

// ****************************************************************
// Register select codes (middle five bits)
// ****************************************************************
`define SEL_OC_BRIDGES_5_TO_8 5'h0E
`define SEL_OC_BRIDGES_9_TO_12 5'h1E
`define SEL_OL_BRIDGES_1_TO_4 5'h01

// ****************************************************************
// Values and sizes
// ****************************************************************
`define STATUS_RESET_VALUE 8'h00
`define STATUS_WIDTH 8
`define BRIDGE_COUNT_FULL 12

`endif

/* hdl/fault_status_pkg.sv */
/*
  Types for the half-bridge fault status bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fault_status_pkg;

  // Address byte of one command as it arrives from the frame engine
  typedef struct packed {
    logic op;
    logic [4:0] sel;
    logic access_type;
    logic fixed_one;
  } addr_byte_t;

  // Read answer carried back to the frame engine
  typedef struct packed {
    logic hit;
    logic [7:0] data;
  } read_answer_t;

endpackage

/* hdl/fault_flag_latch.sv */
/*
  One byte of sticky fault flags with byte-wide clear.
  Assumes detect inputs are synchronous to mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_defines.svh"

module fault_flag_latch #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Flag control
  input wire logic [WIDTH-1:0] detect_i,
  input wire logic [WIDTH-1:0] present_i,
  input wire logic clear_i,
  // Flag state
  output logic [WIDTH-1:0] flags_o
);

  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  // Set wins over clear; absent channels never set
  assign flags_d = ((clear_i ? '0 : flags_q) | detect_i) & present_i;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= WIDTH'(`STATUS_RESET_VALUE);
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;

endmodule
`default_nettype wire

/* hdl/halfbridge_fault_status_regs.sv */
/*
  Status bank for overcurrent flags of bridges 5 to 12 and open-load
  flags of bridges 1 to 4, addressed by the command address byte.
  Assumes a frame engine that presents one address byte per command with
  a one-cycle valid strobe, and fault detectors synchronous to mclk_i.
*/
// Notes on behaviour
// - Address middle bits 01110 select overcurrent bridges 5-8
// - Bridge 8 high at bit 7, pairs downward
// - Overcurrent latches flag and disables that switch
// - Middle bits 11110 select bridges 9-12, same order
// - All flags reset to zero
// - Absent channels read as zero always
// - Middle bits 00001 select open load bridges 1-4
// - Address bit 7 set clears, else plain read
// - Flags clear only by controller command
// - Load error summary is OR of flags
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_defines.svh"

module halfbridge_fault_status_regs #(
  parameter int BRIDGE_COUNT = `BRIDGE_COUNT_FULL
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Command from frame engine
  input wire logic cmd_valid_i,
  input wire fault_status_pkg::addr_byte_t cmd_addr_i,
  // Fault detectors, high side above low side per bridge
  input wire logic [7:0] oc_detect_5_to_8_i,
  input wire logic [7:0] oc_detect_9_to_12_i,
  input wire logic [7:0] ol_detect_1_to_4_i,
  // Flags held in other banks
  input wire logic load_error_other_i,
  // Read answer
  output fault_status_pkg::read_answer_t rd_answer_o,
  // Switch control and summary
  output logic [15:0] switch_disable_o,
  output logic load_error_summary_o
);

  // ****************************************************************
  // Channel presence
  // ****************************************************************
  logic [7:0] present_5_to_8;
  logic [7:0] present_9_to_12;
  logic [7:0] present_1_to_4;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_present
      assign present_1_to_4[gi] = (1 + gi / 2) <= BRIDGE_COUNT;
      assign present_5_to_8[gi] = (5 + gi / 2) <= BRIDGE_COUNT;
      assign present_9_to_12[gi] = (9 + gi / 2) <= BRIDGE_COUNT;
    end
  endgenerate

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic sel_match(input fault_status_pkg::addr_byte_t a,
                                     input logic [4:0] code);
    sel_match = (a.sel == code) && a.fixed_one;
  endfunction

  wire hit_oc_5_to_8 = cmd_valid_i && sel_match(cmd_addr_i, `SEL_OC_BRIDGES_5_TO_8);
  wire hit_oc_9_to_12 = cmd_valid_i && sel_match(cmd_addr_i, `SEL_OC_BRIDGES_9_TO_12);
  wire hit_ol_1_to_4 = cmd_valid_i && sel_match(cmd_addr_i, `SEL_OL_BRIDGES_1_TO_4);
  wire any_hit = hit_oc_5_to_8 || hit_oc_9_to_12 || hit_ol_1_to_4;
  wire clear_oc_5_to_8 = hit_oc_5_to_8 && cmd_addr_i.op;
  wire clear_oc_9_to_12 = hit_oc_9_to_12 && cmd_addr_i.op;
  wire clear_ol_1_to_4 = hit_ol_1_to_4 && cmd_addr_i.op;

  // ****************************************************************
  // Flag banks
  // ****************************************************************
  logic [7:0] oc_5_to_8;
  logic [7:0] oc_9_to_12;
  logic [7:0] ol_1_to_4;

  fault_flag_latch #(.WIDTH(8)) u_oc_5_to_8 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .detect_i(oc_detect_5_to_8_i),
    .present_i(present_5_to_8),
    .clear_i(clear_oc_5_to_8),
    .flags_o(oc_5_to_8)
  );

  fault_flag_latch #(.WIDTH(8)) u_oc_9_to_12 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .detect_i(oc_detect_9_to_12_i),
    .present_i(present_9_to_12),
    .clear_i(clear_oc_9_to_12),
    .flags_o(oc_9_to_12)
  );

  fault_flag_latch #(.WIDTH(8)) u_ol_1_to_4 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .detect_i(ol_detect_1_to_4_i),
    .present_i(present_1_to_4),
    .clear_i(clear_ol_1_to_4),
    .flags_o(ol_1_to_4)
  );

  // ****************************************************************
  // Read path and outputs
  // ****************************************************************
  wire [7:0] rd_select = hit_oc_5_to_8 ? oc_5_to_8 :
                         hit_oc_9_to_12 ? oc_9_to_12 :
                         hit_ol_1_to_4 ? ol_1_to_4 : `STATUS_RESET_VALUE;

  fault_status_pkg::read_answer_t rd_answer_q;
  fault_status_pkg::read_answer_t rd_answer_d;

  // Answer carries the value seen before any clear in the same command
  assign rd_answer_d = {any_hit, rd_select};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_answer_q <= '0;
    end else begin
      rd_answer_q <= rd_answer_d;
    end
  end

  assign rd_answer_o = rd_answer_q;
  assign switch_disable_o = {oc_9_to_12, oc_5_to_8};
  assign load_error_summary_o = (|oc_5_to_8) || (|oc_9_to_12) || (|ol_1_to_4)
                                || load_error_other_i;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  wire [23:0] all_flags = {ol_1_to_4, oc_9_to_12, oc_5_to_8};
  wire [23:0] all_present = {present_1_to_4, present_9_to_12, present_5_to_8};
  wire [23:0] all_clear = {{8{clear_ol_1_to_4}}, {8{clear_oc_9_to_12}}, {8{clear_oc_5_to_8}}};
  wire [23:0] all_detect = {ol_detect_1_to_4_i, oc_detect_9_to_12_i, oc_detect_5_to_8_i};

  property p_oc_5_to_8_read;
    (cmd_valid_i && cmd_addr_i.sel == 5'h0E && cmd_addr_i.fixed_one)
      |=> rd_answer_o.hit && rd_answer_o.data == $past(oc_5_to_8);
  endproperty
  a_oc_5_to_8_read: assert property (p_oc_5_to_8_read) else $error("bad read 5-8");

  property p_oc_9_to_12_read;
    (cmd_valid_i && cmd_addr_i.sel == 5'h1E && cmd_addr_i.fixed_one)
      |=> rd_answer_o.hit && rd_answer_o.data == $past(oc_9_to_12);
  endproperty
  a_oc_9_to_12_read: assert property (p_oc_9_to_12_read) else $error("bad read 9-12");

  property p_ol_1_to_4_read;
    (cmd_valid_i && cmd_addr_i.sel == 5'h01 && cmd_addr_i.fixed_one)
      |=> rd_answer_o.hit && rd_answer_o.data == $past(ol_1_to_4);
  endproperty
  a_ol_1_to_4_read: assert property (p_ol_1_to_4_read) else $error("bad read OL 1-4");

  property p_latch_and_disable;
    (|(oc_detect_5_to_8_i & present_5_to_8))
      |=> ((switch_disable_o[7:0] & $past(oc_detect_5_to_8_i & present_5_to_8))
           == $past(oc_detect_5_to_8_i & present_5_to_8));
  endproperty
  a_latch_and_disable: assert property (p_latch_and_disable) else $error("OC not latched");

  property p_reset_zero;
    disable iff (1'b0) rst_i |=> all_flags == 24'h000000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset");

  property p_absent_zero;
    (all_flags & ~all_present) == 24'h000000;
  endproperty
  a_absent_zero: assert property (p_absent_zero) else $error("absent flag set");

  property p_read_keeps;
    (cmd_valid_i && !cmd_addr_i.op && all_detect == 24'h000000) |=> $stable(all_flags);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("plain read changed flags");

  property p_no_self_clear;
    1'b1 |=> (($past(all_flags) & ~all_flags & ~$past(all_clear)) == 24'h000000);
  endproperty
  a_no_self_clear: assert property (p_no_self_clear) else $error("flag dropped uncommanded");

  property p_summary;
    load_error_summary_o == ((|all_flags) || load_error_other_i);
  endproperty
  a_summary: assert property (p_summary) else $error("summary mismatch");

  property p_set_beats_clear;
    (|(all_clear & all_detect & all_present))
      |=> ((all_flags & $past(all_clear & all_detect & all_present))
           == $past(all_clear & all_detect & all_present));
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("fault lost in clear");

  property p_cover_clear;
    clear_oc_5_to_8 && (|oc_5_to_8);
  endproperty
  c_cover_clear: cover property (p_cover_clear);

  property p_cover_race;
    |(all_clear & all_detect & all_present);
  endproperty
  c_cover_race: cover property (p_cover_race);

  property p_cover_summary_drop;
    $fell(load_error_summary_o);
  endproperty
  c_cover_summary_drop: cover property (p_cover_summary_drop);

endmodule
`default_nettype wire

/* test/fault_ctrl_model.sv */
/*
  Controller model that issues address bytes to the fault status bank.
  Assumes commands are taken at the rising edge of mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module fault_ctrl_model (
  // Clock
  input wire logic mclk_i,
  // Answer from the bank
  input wire fault_status_pkg::read_answer_t rd_answer_i,
  // Command to the bank
  output logic cmd_valid_o,
  output fault_status_pkg::addr_byte_t cmd_addr_o
);
  // ****************************************************************
  // One command: read or clear
  // ****************************************************************
  initial begin
    cmd_valid_o = 1'b0;
    cmd_addr_o = 8'h00;
  end

  task automatic access(input logic clr, input logic [4:0] sel, input logic one,
                        output fault_status_pkg::read_answer_t ans);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_addr_o <= {clr, sel, 1'b0, one};
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    cmd_addr_o <= ~{clr, sel, 1'b0, one};
    #1;
    ans = rd_answer_i;
  endtask
endmodule

`default_nettype wire

/* test/halfbridge_fault_status_regs_bench.sv */
/*
  Self-checking bench for the fault status bank.
  Assumes the design files and the controller model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_defines.svh"

module halfbridge_fault_status_regs_bench;
  localparam int NBR = 10;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] det [3] = '{8'h00, 8'h00, 8'h00};
  logic other = 1'b0;
  logic cmd_valid;
  fault_status_pkg::addr_byte_t cmd_addr;
  fault_status_pkg::read_answer_t ans;
  fault_status_pkg::read_answer_t rd_answer;
  logic [15:0] sw_off;
  logic summary;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [4:0] sels [3] = '{`SEL_OC_BRIDGES_5_TO_8, `SEL_OC_BRIDGES_9_TO_12,
                           `SEL_OL_BRIDGES_1_TO_4};
  logic [7:0] pats [3] = '{8'hA5, 8'hF6, 8'h81};
  logic [7:0] masks [3] = '{8'hFF, 8'hFF >> (2 * (12 - NBR)), 8'hFF};
  logic [7:0] exp;

  always #20 mclk_i = ~mclk_i;

  halfbridge_fault_status_regs #(.BRIDGE_COUNT(NBR)) uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_addr_i(cmd_addr),
    .oc_detect_5_to_8_i(det[0]), .oc_detect_9_to_12_i(det[1]),
    .ol_detect_1_to_4_i(det[2]), .load_error_other_i(other),
    .rd_answer_o(rd_answer), .switch_disable_o(sw_off), .load_error_summary_o(summary)
  );

  fault_ctrl_model ctrl (
    .mclk_i(mclk_i), .rd_answer_i(rd_answer), .cmd_valid_o(cmd_valid), .cmd_addr_o(cmd_addr)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic rd(input logic clr, input logic [4:0] sel, input logic [8:0] want,
                    input string what);
    ctrl.access(clr, sel, 1'b1, ans);
    check(what, {7'h00, ans}, {7'h00, want});
  endtask

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(1'b0, sels[i], 9'h100, "reset value");
    end
    for (int i = 0; i < 3; i++) begin
      exp = pats[i] & masks[i];
      @(posedge mclk_i);
      det[i] <= pats[i];
      @(posedge mclk_i);
      det[i] <= 8'h00;
      #1;
      check("switch off", sw_off, (i == 0) ? {8'h00, exp} : (i == 1) ? {exp, 8'h00} : 16'h0000);
      check("summary set", {15'h0000, summary}, 16'h0001);
      rd(1'b0, sels[i], {1'b1, exp}, "read");
      rd(1'b0, sels[i], {1'b1, exp}, "read again");
      rd(1'b1, sels[i], {1'b1, exp}, "clear");
      rd(1'b0, sels[i], 9'h100, "after clear");
      check("summary clear", {15'h0000, summary}, 16'h0000);
      check("switch on", sw_off, 16'h0000);
    end
    rd(1'b1, 5'h06, 9'h000, "unmapped");
    ctrl.access(1'b0, `SEL_OC_BRIDGES_5_TO_8, 1'b0, ans);
    check("fixed bit low", {7'h00, ans}, 16'h0000);
    // Fault stands only at the edge that takes the clear
    fork
      rd(1'b1, `SEL_OC_BRIDGES_5_TO_8, 9'h100, "clear with fault");
      begin
        @(posedge mclk_i);
        det[0] <= 8'h01;
        @(posedge mclk_i);
        det[0] <= 8'h00;
      end
    join
    rd(1'b1, `SEL_OC_BRIDGES_5_TO_8, 9'h101, "kept");
    rd(1'b0, `SEL_OC_BRIDGES_5_TO_8, 9'h100, "cleared");
    @(posedge mclk_i);
    other <= 1'b1;
    #1;
    check("summary other", {15'h0000, summary}, 16'h0001);
    @(posedge mclk_i);
    other <= 1'b0;
    #1;
    check("summary drop", {15'h0000, summary}, 16'h0000);
    give_verdict();
  end
endmodule

`default_nettype wire
